// >>> design/prc_defines.svh
`ifndef PRC_DEFINES_SVH
`define PRC_DEFINES_SVH
// Register indices; byte address is four times the index.
`define PRC_IDX_THIRD 4'h0
`define PRC_IDX_FIRST 4'h1
`define PRC_IDX_SECOND 4'h2
`define PRC_ADDR_W 4
// Reset values.
`define PRC_RST_THIRD 8'h00
`define PRC_RST_FIRST 8'h0c
`define PRC_RST_SECOND 8'h00
// Field positions, first register.
`define PRC_F1_SP1_ROUTE_A 7
`define PRC_F1_SER1_CLK 6
`define PRC_F1_SER1_TXRX_HI 5
`define PRC_F1_SER1_TXRX_LO 4
`define PRC_F1_TIM4_DMA_HI 3
`define PRC_F1_TIM4_DMA_LO 2
`define PRC_F1_CONV_DMA_HI 1
`define PRC_F1_CONV_DMA_LO 0
// Field positions, second register.
`define PRC_F2_BREAK 7
`define PRC_F2_T3TRIG_B 6
`define PRC_F2_SP2 5
`define PRC_F2_T3_SLOW 4
`define PRC_F2_T2_SLOW 3
`define PRC_F2_T3TRIG_A 2
`define PRC_F2_T2TRIG 1
`define PRC_F2_CONVTRIG 0
// Field positions, third register.
`define PRC_F3_T2CH2 7
`define PRC_F3_T2CH1 6
`define PRC_F3_CLKOUT 5
`define PRC_F3_T3CH2 4
`define PRC_F3_T3CH1 3
`define PRC_F3_SER3_CLK 2
`define PRC_F3_SER3_TXRX 1
`define PRC_F3_SP1_ROUTE_B 0
// Writable masks per variant.
`define PRC_MASK_FULL 8'hff
`define PRC_MASK_SECOND_SMALL 8'h1f
`define PRC_MASK_THIRD_LD20 8'hff
`define PRC_MASK_THIRD_BIG 8'h3f
`define PRC_MASK_NONE 8'h00
// Bus response codes.
`define PRC_RESP_OKAY 2'b00
`define PRC_RESP_SLVERR 2'b10
`endif

// >>> design/prc_pkg.sv
package prc_pkg;
  // Device variant that decides which bits exist.
  typedef enum logic [1:0] {
    PRC_VAR_LOW_20PIN = 2'h0,
    PRC_VAR_LOW_OTHER = 2'h1,
    PRC_VAR_MEDIUM = 2'h3,
    PRC_VAR_HIGH = 2'h2
  } prc_variant_t;
  // Pin groups for the first serial peripheral.
  typedef enum logic [1:0] {
    PRC_SP1_PORT_B = 2'h0,
    PRC_SP1_PORT_AC = 2'h1,
    PRC_SP1_PORT_F = 2'h2
  } prc_sp1_group_t;
  // Timer trigger sources.
  typedef enum logic [1:0] {
    PRC_TRIG_DEFAULT_PIN = 2'h0,
    PRC_TRIG_ALT_PIN = 2'h1,
    PRC_TRIG_THIRD_PIN = 2'h2,
    PRC_TRIG_SLOW_OSC = 2'h3
  } prc_trig_src_t;
  // Bus slave phases.
  typedef enum logic [1:0] {
    PRC_BUS_IDLE = 2'h0,
    PRC_BUS_RESP = 2'h1
  } prc_bus_state_t;
endpackage

// >>> design/prc_axil_slave.sv
`timescale 1ns/1ps
`include "prc_defines.svh"
// ****************************************
// AXI4-Lite slave front end
// ****************************************
module prc_axil_slave
(
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic [31:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [31:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic wr_en, // One-cycle register write.
  output logic [`PRC_ADDR_W-1:0] wr_idx, // Register index of the write.
  output logic [7:0] wr_data, // Write byte.
  input wire logic wr_ok, // Index is mapped for writes.
  output logic [`PRC_ADDR_W-1:0] rd_idx, // Register index of the read.
  input wire logic [7:0] rd_data, // Read byte.
  input wire logic rd_ok // Index is mapped for reads.
);
  import prc_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic [`PRC_ADDR_W-1:0] aw_idx;
    logic w_got;
    logic [7:0] w_byte;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rbyte;
  } prc_slv_t;

  prc_slv_t st;
  prc_slv_t next_st;
  logic do_write;

  // Index comes from the word address; upper address bits beyond the index range fold to unmapped.
  function automatic logic [`PRC_ADDR_W-1:0] word_idx(input logic [31:0] a);
    logic [`PRC_ADDR_W-1:0] r;
    r = (a[31:2+`PRC_ADDR_W] != '0) ? {`PRC_ADDR_W{1'b1}} : a[2+`PRC_ADDR_W-1:2];
    return r;
  endfunction

  // Accept each write channel independently, answer once both are in.
  always_comb
  begin
    next_st = st;
    do_write = 1'b0;
    if (s_axi_awvalid && !st.aw_got)
    begin
      next_st.aw_got = 1'b1;
      next_st.aw_idx = word_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && !st.w_got)
    begin
      next_st.w_got = 1'b1;
      next_st.w_byte = s_axi_wdata[7:0];
      next_st.w_lane = s_axi_wstrb[0];
    end
    if (st.aw_got && st.w_got && !st.bvalid)
    begin
      do_write = wr_ok && st.w_lane;
      next_st.bvalid = 1'b1;
      next_st.bresp = wr_ok ? `PRC_RESP_OKAY : `PRC_RESP_SLVERR;
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
    end
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !st.rvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rbyte = rd_ok ? rd_data : 8'h00;
      next_st.rresp = rd_ok ? `PRC_RESP_OKAY : `PRC_RESP_SLVERR;
    end
    else if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
    end
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  assign s_axi_awready = ce && !st.aw_got;
  assign s_axi_wready = ce && !st.w_got;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = ce && !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = {24'h000000, st.rbyte};
  assign wr_en = ce && do_write;
  assign wr_idx = st.aw_idx;
  assign wr_data = st.w_byte;
  assign rd_idx = word_idx(s_axi_araddr);
endmodule

// >>> design/prc_remap_reg.sv
`timescale 1ns/1ps
`include "prc_defines.svh"
// ****************************************
// One byte-wide remap register
// ****************************************
module prc_remap_reg
#(
  parameter logic [7:0] RST_VAL = 8'h00, // Reset value.
  parameter logic [7:0] WR_MASK = 8'hff // Implemented bits.
)
(
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic wr, // Write strobe.
  input wire logic [7:0] din, // Write byte.
  output logic [7:0] q // Current contents, unimplemented bits zero.
);
  typedef struct packed {
    logic [7:0] val;
  } prc_reg_t;

  prc_reg_t st;
  prc_reg_t next_st;

  // Unimplemented bits never store anything, so they read back as zero.
  always_comb
  begin
    next_st = st;
    if (wr)
    begin
      next_st.val = din & WR_MASK;
    end
  end

  // Register.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st.val <= RST_VAL & WR_MASK;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  assign q = st.val;
endmodule

// >>> design/prc_top.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "prc_defines.svh"
// Overview of operation
// - First reg bit7 moves serial peripheral 1
// - First reg bit6 moves serial port1 clock
// - First reg bits5:4 pick serial1 pair
// - First reg bits3:2 timer4 DMA channel
// - First reg bits1:0 converter DMA channel
// - Second reg bit7 moves both break inputs
// - Second reg bit6 gives timer3 third pin
// - Second reg bit5 moves serial peripheral 2
// - Second reg bit4 timer3 trigger slow oscillator
// - Second reg bit3 timer2 trigger slow oscillator
// - Second reg bit2 timer3 trigger pin
// - Second reg bit1 timer2 trigger pin
// - Second reg bit0 converter trigger pin
// - Second reg bits7:5 reserved small variants
// - Third reg only in some variants
// - Third reg bits7:6 timer2 channels low20
// - Third reg bit5 moves clock output
// - Third reg bits4:3 timer3 channels
// - Third reg bit2 serial port3 clock
// - Third reg bit1 serial port3 pair
// - Third reg bit0 peripheral 1 port F
module prc_top
#(
  parameter prc_pkg::prc_variant_t VARIANT = prc_pkg::PRC_VAR_HIGH // Device variant.
)
(
  input wire logic clk, // System clock, 200 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable; low freezes all state.
  input wire logic [31:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [31:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output prc_pkg::prc_sp1_group_t serial_periph1_group, // Pin group of serial peripheral 1.
  output logic serport1_clock_route, // Serial port 1 clock on alternate pin.
  output logic [1:0] serport1_txrx_route, // Serial port 1 pin pair code.
  output logic [3:0] timer4_dma_channel, // One-hot DMA channel of timer 4.
  output logic [3:0] converter_dma_channel, // One-hot DMA channel of the converter.
  output logic timers_break_route, // Break inputs on alternate pins.
  output prc_pkg::prc_trig_src_t timer3_trigger_src, // Timer 3 trigger source.
  output prc_pkg::prc_trig_src_t timer2_trigger_src, // Timer 2 trigger source.
  output logic serial_periph2_route, // Serial peripheral 2 on port I group.
  output logic converter_trigger_route, // Converter trigger on alternate pin.
  output logic timer2_ch2_route, // Timer 2 channel 2 on alternate pin.
  output logic timer2_ch1_route, // Timer 2 channel 1 on alternate pin.
  output logic clock_out_route, // Clock output on alternate pin.
  output logic timer3_ch2_route, // Timer 3 channel 2 on alternate pin.
  output logic timer3_ch1_route, // Timer 3 channel 1 on alternate pin.
  output logic serport3_clock_route, // Serial port 3 clock on alternate pin.
  output logic serport3_txrx_route, // Serial port 3 pair on port F.
  output logic serport1_txrx_bad // First register holds the reserved pair code.
);
  import prc_pkg::*;

  // ****************************************
  // Variant dependent masks
  // ****************************************

  // Small variants lack the upper second-register bits; of them only the 20-pin part has the third register.
  // Every low-density part counts as small here, the 20-pin one included.
  localparam logic SMALL = (VARIANT != PRC_VAR_HIGH);
  localparam logic HAS_THIRD = (VARIANT == PRC_VAR_LOW_20PIN) || (VARIANT == PRC_VAR_HIGH);
  localparam logic [7:0] MASK_SECOND = SMALL ? `PRC_MASK_SECOND_SMALL : `PRC_MASK_FULL;
  // Timer 2 channel bits exist only on the 20-pin low-density part.
  localparam logic [7:0] MASK_THIRD = !HAS_THIRD ? `PRC_MASK_NONE :
    ((VARIANT == PRC_VAR_LOW_20PIN) ? `PRC_MASK_THIRD_LD20 : `PRC_MASK_THIRD_BIG);

  // ****************************************
  // Bus and registers
  // ****************************************

  logic wr_en;
  logic [`PRC_ADDR_W-1:0] wr_idx;
  logic [7:0] wr_data;
  logic wr_ok;
  logic [`PRC_ADDR_W-1:0] rd_idx;
  logic [7:0] rd_data;
  logic rd_ok;
  logic [7:0] reg_first;
  logic [7:0] reg_second;
  logic [7:0] reg_third;

  prc_axil_slave u_slave
  (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_ok(wr_ok),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // An absent third register answers as an unmapped address.
  always_comb
  begin
    if (wr_idx == `PRC_IDX_FIRST)
    begin
      wr_ok = 1'b1;
    end
    else if (wr_idx == `PRC_IDX_SECOND)
    begin
      wr_ok = 1'b1;
    end
    else if (wr_idx == `PRC_IDX_THIRD)
    begin
      wr_ok = HAS_THIRD;
    end
    else
    begin
      wr_ok = 1'b0;
    end
  end

  // Read mux; stored bits come back as written, reserved ones as zero.
  always_comb
  begin
    rd_data = 8'h00;
    rd_ok = 1'b0;
    if (rd_idx == `PRC_IDX_FIRST)
    begin
      rd_data = reg_first;
      rd_ok = 1'b1;
    end
    else if (rd_idx == `PRC_IDX_SECOND)
    begin
      rd_data = reg_second;
      rd_ok = 1'b1;
    end
    else if (rd_idx == `PRC_IDX_THIRD)
    begin
      rd_data = reg_third;
      rd_ok = HAS_THIRD;
    end
  end

  prc_remap_reg #(.RST_VAL(`PRC_RST_FIRST), .WR_MASK(`PRC_MASK_FULL)) u_first
  (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr(wr_en && (wr_idx == `PRC_IDX_FIRST)),
    .din(wr_data),
    .q(reg_first)
  );

  prc_remap_reg #(.RST_VAL(`PRC_RST_SECOND), .WR_MASK(MASK_SECOND)) u_second
  (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr(wr_en && (wr_idx == `PRC_IDX_SECOND)),
    .din(wr_data),
    .q(reg_second)
  );

  prc_remap_reg #(.RST_VAL(`PRC_RST_THIRD), .WR_MASK(MASK_THIRD)) u_third
  (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr(wr_en && (wr_idx == `PRC_IDX_THIRD)),
    .din(wr_data),
    .q(reg_third)
  );

  // ****************************************
  // Routing decode
  // ****************************************

  typedef struct packed {
    prc_sp1_group_t sp1;
    logic ser1_clk;
    logic [1:0] ser1_txrx;
    logic [3:0] tim4_dma;
    logic [3:0] conv_dma;
    logic brk;
    prc_trig_src_t t3trig;
    prc_trig_src_t t2trig;
    logic sp2;
    logic convtrig;
    logic t2ch2;
    logic t2ch1;
    logic clkout;
    logic t3ch2;
    logic t3ch1;
    logic ser3_clk;
    logic ser3_txrx;
    logic ser1_bad;
  } prc_route_t;

  prc_route_t st;
  prc_route_t next_st;
  logic [1:0] t4_sel;
  logic [1:0] cv_sel;
  wire [3:0] t4_hot;
  wire [3:0] cv_hot;

  assign t4_sel = reg_first[`PRC_F1_TIM4_DMA_HI:`PRC_F1_TIM4_DMA_LO];
  assign cv_sel = reg_first[`PRC_F1_CONV_DMA_HI:`PRC_F1_CONV_DMA_LO];

  // Decode follows the register contents directly; outputs are registered for clean timing.
  always_comb
  begin
    next_st = st;
    // Port F group wins over the port A/C group when both are set.
    if (reg_third[`PRC_F3_SP1_ROUTE_B])
    begin
      next_st.sp1 = PRC_SP1_PORT_F;
    end
    else if (reg_first[`PRC_F1_SP1_ROUTE_A])
    begin
      next_st.sp1 = PRC_SP1_PORT_AC;
    end
    else
    begin
      next_st.sp1 = PRC_SP1_PORT_B;
    end
    next_st.ser1_clk = reg_first[`PRC_F1_SER1_CLK];
    next_st.ser1_txrx = reg_first[`PRC_F1_SER1_TXRX_HI:`PRC_F1_SER1_TXRX_LO];
    // The reserved pair code is passed on but also flagged so software misuse is visible.
    next_st.ser1_bad = &reg_first[`PRC_F1_SER1_TXRX_HI:`PRC_F1_SER1_TXRX_LO];
    next_st.brk = reg_second[`PRC_F2_BREAK];
    // Slow oscillator overrides pin choices; trusts software to have started it.
    if (reg_second[`PRC_F2_T3_SLOW])
    begin
      next_st.t3trig = PRC_TRIG_SLOW_OSC;
    end
    else if (reg_second[`PRC_F2_T3TRIG_B])
    begin
      next_st.t3trig = PRC_TRIG_THIRD_PIN;
    end
    else if (reg_second[`PRC_F2_T3TRIG_A])
    begin
      next_st.t3trig = PRC_TRIG_ALT_PIN;
    end
    else
    begin
      next_st.t3trig = PRC_TRIG_DEFAULT_PIN;
    end
    if (reg_second[`PRC_F2_T2_SLOW])
    begin
      next_st.t2trig = PRC_TRIG_SLOW_OSC;
    end
    else if (reg_second[`PRC_F2_T2TRIG])
    begin
      next_st.t2trig = PRC_TRIG_ALT_PIN;
    end
    else
    begin
      next_st.t2trig = PRC_TRIG_DEFAULT_PIN;
    end
    next_st.sp2 = reg_second[`PRC_F2_SP2];
    next_st.convtrig = reg_second[`PRC_F2_CONVTRIG];
    next_st.t2ch2 = reg_third[`PRC_F3_T2CH2];
    next_st.t2ch1 = reg_third[`PRC_F3_T2CH1];
    next_st.clkout = reg_third[`PRC_F3_CLKOUT];
    next_st.t3ch2 = reg_third[`PRC_F3_T3CH2];
    next_st.t3ch1 = reg_third[`PRC_F3_T3CH1];
    next_st.ser3_clk = reg_third[`PRC_F3_SER3_CLK];
    next_st.ser3_txrx = reg_third[`PRC_F3_SER3_TXRX];
    next_st.tim4_dma = t4_hot;
    next_st.conv_dma = cv_hot;
  end

  // One-hot DMA channel selects, one bit per channel number.
  for (genvar ch = 0; ch < 4; ch++)
  begin : g_dma
    assign t4_hot[ch] = (t4_sel == 2'(ch));
    assign cv_hot[ch] = (cv_sel == 2'(ch));
  end

  // Route register; reset values match the decode of the register reset values.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.tim4_dma <= 4'h8;
      st.conv_dma <= 4'h1;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  assign serial_periph1_group = st.sp1;
  assign serport1_clock_route = st.ser1_clk;
  assign serport1_txrx_route = st.ser1_txrx;
  assign timer4_dma_channel = st.tim4_dma;
  assign converter_dma_channel = st.conv_dma;
  assign timers_break_route = st.brk;
  assign timer3_trigger_src = st.t3trig;
  assign timer2_trigger_src = st.t2trig;
  assign serial_periph2_route = st.sp2;
  assign converter_trigger_route = st.convtrig;
  assign timer2_ch2_route = st.t2ch2;
  assign timer2_ch1_route = st.t2ch1;
  assign clock_out_route = st.clkout;
  assign timer3_ch2_route = st.t3ch2;
  assign timer3_ch1_route = st.t3ch1;
  assign serport3_clock_route = st.ser3_clk;
  assign serport3_txrx_route = st.ser3_txrx;
  assign serport1_txrx_bad = st.ser1_bad;
endmodule

// >>> tb/prc_monitor.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module prc_monitor
#(
  parameter prc_pkg::prc_variant_t VARIANT = prc_pkg::PRC_VAR_HIGH // Variant.
)
(
  input wire logic clk, // Clock.
  input wire logic rst_n, // Reset.
  input wire logic s_axi_awvalid, // Aw valid.
  input wire logic s_axi_awready, // Aw ready.
  input wire logic s_axi_wvalid, // W valid.
  input wire logic s_axi_wready, // W ready.
  input wire logic s_axi_bvalid, // B valid.
  input wire logic s_axi_bready, // B ready.
  input wire logic [1:0] s_axi_bresp, // B code.
  input wire logic s_axi_arvalid, // Ar valid.
  input wire logic s_axi_arready, // Ar ready.
  input wire logic s_axi_rvalid, // R valid.
  input wire logic s_axi_rready, // R ready.
  input wire logic [31:0] s_axi_rdata, // R data.
  input wire logic [1:0] serport1_txrx_route, // Pair code.
  input wire logic serport1_txrx_bad, // Reserved pair flag.
  input wire logic [3:0] timer4_dma_channel, // Timer 4 channel.
  input wire logic [3:0] converter_dma_channel, // Converter channel.
  input wire prc_pkg::prc_trig_src_t timer2_trigger_src, // Timer 2 source.
  input wire logic timer2_ch1_route, // Channel 1 route.
  input wire logic timer2_ch2_route // Channel 2 route.
);
  import prc_pkg::*;
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_r_order;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_r_high;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  property p_bad;
    serport1_txrx_bad == (serport1_txrx_route == 2'b11);
  endproperty
  property p_dma;
    $onehot(timer4_dma_channel) && $onehot(converter_dma_channel);
  endproperty
  property p_t2src;
    timer2_trigger_src != PRC_TRIG_THIRD_PIN;
  endproperty
  // Outside the small 20-pin part the two top bits of the third register do nothing.
  property p_t2ch;
    VARIANT != PRC_VAR_LOW_20PIN |-> !timer2_ch1_route && !timer2_ch2_route;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  a_r_order: assert property (p_r_order) else $error("read taken while busy");
  a_r_high: assert property (p_r_high) else $error("read upper bits set");
  a_bad: assert property (p_bad) else $error("reserved pair flag wrong");
  a_dma: assert property (p_dma) else $error("dma channel not one hot");
  a_t2src: assert property (p_t2src) else $error("timer 2 source wrong");
  a_t2ch: assert property (p_t2ch) else $error("channel route set");
  c_wr: cover property (p_wr_resp);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
  c_bad: cover property (serport1_txrx_bad);
endmodule
bind prc_top prc_monitor #(.VARIANT(VARIANT)) prc_monitor_i (.*);

// >>> tb/prc_top_bench.sv
`timescale 1ns/1ps
// ****
// Remap control bench
// ****
module prc_top_bench;
  import prc_pkg::*;
  logic clk, rst_n, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, serport1_clock_route, timers_break_route;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, lfsr;
  logic [3:0] s_axi_wstrb, timer4_dma_channel, converter_dma_channel;
  logic [1:0] s_axi_bresp, s_axi_rresp, serport1_txrx_route;
  logic serial_periph2_route, converter_trigger_route, timer2_ch2_route, timer2_ch1_route, clock_out_route;
  logic timer3_ch2_route, timer3_ch1_route, serport3_clock_route, serport3_txrx_route, serport1_txrx_bad;
  prc_sp1_group_t serial_periph1_group;
  prc_trig_src_t timer3_trigger_src, timer2_trigger_src;
  logic [7:0] exp_reg [3];
  int fail_count, comparisons;
  prc_top prc_top_i (.*);
  // Free-running 200 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Watchdog: the tests need a few hundred cycles, this allows twenty thousand.
  initial
  begin
    #100us;
    fail_count++;
    close_out();
  end
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  function automatic bit mapped(input logic [31:0] a);
    return a[31:6] == 26'h0 && a[5:2] < 4'h3;
  endfunction
  function automatic logic [7:0] mask_of(input logic [1:0] i);
    return i == 2'h0 ? 8'h3f : 8'hff;
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
    comparisons++;
    if (seen !== expv)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    exp_reg = '{8'h00, 8'h0c, 8'h00};
  endtask
  // Write master; the leading edge keeps bready from being set twice in one step.
  // Readies and answers are sampled at the falling edge, where they stand for the next rising edge.
  task automatic bus_write(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    logic aw_rdy, w_rdy, b_seen;
    logic [1:0] br;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {lfsr[31:8], d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge clk);
      {aw_rdy, w_rdy, b_seen, br} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge clk);
      if (aw_rdy)
        s_axi_awvalid <= 1'b0;
      if (w_rdy)
        s_axi_wvalid <= 1'b0;
      n++;
    end
    while (!b_seen && n < 50);
    s_axi_bready <= 1'b0;
    if (mapped(a) && s[0])
      exp_reg[a[3:2]] = d & mask_of(a[3:2]);
    check("bresp", {29'h0, b_seen, br}, mapped(a) ? 32'h4 : 32'h6);
  endtask
  task automatic bus_read(input logic [31:0] a);
    int n;
    logic ar_rdy, r_seen;
    logic [31:0] rd;
    logic [1:0] rr;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge clk);
      {ar_rdy, r_seen, rd, rr} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge clk);
      if (ar_rdy)
        s_axi_arvalid <= 1'b0;
      n++;
    end
    while (!r_seen && n < 50);
    s_axi_rready <= 1'b0;
    check("rdata", rd, mapped(a) ? {24'h0, exp_reg[a[3:2]]} : 32'h0);
    check("rresp", {29'h0, r_seen, rr}, mapped(a) ? 32'h4 : 32'h6);
  endtask
  // Route outputs lag the register by one edge, so one edge passes first.
  task automatic check_routes();
    logic [1:0] sp1, t3, t2;
    @(posedge clk);
    sp1 = exp_reg[0][0] ? 2'h2 : {1'b0, exp_reg[1][7]};
    t3 = exp_reg[2][4] ? 2'h3 : exp_reg[2][6] ? 2'h2 : {1'b0, exp_reg[2][2]};
    t2 = exp_reg[2][3] ? 2'h3 : {1'b0, exp_reg[2][1]};
    check("routes", {4'h0, serial_periph1_group, serport1_clock_route, serport1_txrx_route, serport1_txrx_bad,
      timer4_dma_channel, converter_dma_channel, timers_break_route, timer3_trigger_src, timer2_trigger_src,
      serial_periph2_route, converter_trigger_route, timer2_ch2_route, timer2_ch1_route, clock_out_route,
      timer3_ch2_route, timer3_ch1_route, serport3_clock_route, serport3_txrx_route},
      {4'h0, sp1, exp_reg[1][6:4], exp_reg[1][5:4] == 2'b11, 4'h1 << exp_reg[1][3:2], 4'h1 << exp_reg[1][1:0],
      exp_reg[2][7], t3, t2, exp_reg[2][5], exp_reg[2][0], exp_reg[0][7:1]});
  endtask
  // Main sequence.
  initial
  begin
    {ce, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h40;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    lfsr = 32'haa5e4fca;
    do_reset();
    for (int i = 0; i < 3; i++)
      bus_read(32'(i * 4));
    check_routes();
    $display("test reset done");
    for (int c = 0; c < 4; c++)
    begin
      bus_write(32'h4, {c[0], c[1], {3{c[1:0]}}}, 4'h1);
      check_routes();
    end
    $display("test codes done");
    for (int i = 0; i < 45; i++)
    begin
      lfsr = next_rand(lfsr);
      bus_write(32'((i % 3) * 4), i < 3 ? 8'hff : lfsr[7:0], {lfsr[11:9], 1'b1});
      check_routes();
      bus_read(32'((i % 3) * 4));
    end
    $display("test random done");
    bus_write(32'h8, 8'h55, 4'h0);
    bus_write(32'hc, 8'h55, 4'h1);
    bus_read(32'h8);
    bus_read(32'hc);
    bus_read(32'h40);
    // Clock enable low must hold off every new request and keep the registers.
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    check("ready", {s_axi_awready, s_axi_wready, s_axi_arready}, 32'h0);
    ce <= 1'b1;
    bus_read(32'h4);
    $display("test refused done");
    do_reset();
    for (int i = 0; i < 3; i++)
      bus_read(32'(i * 4));
    check_routes();
    $display("test second reset done");
    close_out();
  end
endmodule
